/* File: reset_and_power_reduction_ctrl.sv */
/*
 * Reset combiner with start-up stretch, timed supply-drop sleep control,
 * peripheral clock gates and bandgap enable, all in one clocked block.
 * Assumes analog comparators deliver clean level flags, fuses are static,
 * and sleep, wake and watchdog pulses come from logic on sys_clk_in.
 */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Sleep-off bit settable only within four cycles after both-bits write.
// - Sleep-off becomes effective three cycles after it is set.
// - Sleep entered while effective turns detector off for that sleep only.
// - Sleep-off bit clears itself three cycles after being set.
// - Gate bit 7 stops the two-wire module clock.
// - Gate bit 6 stops timer 2 only when async select is zero.
// - Gate bit 5 stops timer 0; clearing resumes where it stopped.
// - Gate bit 3 stops timer 1; clearing resumes its prior state.
// - Gate bit 2 stops the SPI clock.
// - Gate bit 1 stops the USART clock.
// - Gate bit 0 shuts the converter and withholds its mux from comparator.
// - Gate bit 4 reserved: reads zero, writes ignored.
// - During reset all registers take initial values; fetch starts after.
// - Port reset follows any active source without waiting for stretch.
// - Internal reset held for fuse-selected stretch after all sources clear.
// - Four sources: supply-up, pin, watchdog, supply-drop.
// - Pin low longer than minimum width resets; fuse can disable.
// - Supply-up reset reasserts at once when supply falls below level.
// - Drop below lower level, longer than minimum time, asserts reset.
// - Watchdog timeout in reset mode gives one-cycle pulse; stretch starts when it falls.
// - Bandgap on when detector fused on, comparator selects it, or converter on.
//////////////////////////////////////////////////////////////////////////////

module reset_and_power_reduction_ctrl #(
    parameter int STRETCH_LONG  = reset_power_pkg::STRETCH_LONG_CYC,
    parameter int STRETCH_SHORT = reset_power_pkg::STRETCH_SHORT_CYC,
    parameter int PIN_MIN       = reset_power_pkg::PIN_MIN_CYC,
    parameter int DROP_MIN      = reset_power_pkg::DROP_MIN_CYC
) (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    input  wire logic       supply_up_ok_in,
    input  wire logic       reset_pin_n_in,
    input  wire logic       supply_drop_in,
    input  wire logic       wdt_timeout_in,
    input  wire logic       wdt_reset_mode_in,
    input  wire logic       pin_reset_disable_fuse_in,
    input  wire logic [2:0] drop_level_fuses_in,
    input  wire logic [1:0] startup_time_fuses_in,
    input  wire logic [3:0] clock_select_fuses_in,
    input  wire logic       sleep_enter_in,
    input  wire logic       sleep_wake_in,
    input  wire logic       timer2_async_select_in,
    input  wire logic       comparator_bandgap_select_in,
    input  wire logic       converter_enable_in,
    output logic            internal_reset_out,
    output logic            io_port_reset_out,
    output logic            fetch_start_out,
    output logic            supply_drop_detector_off_out,
    output logic            two_wire_clock_gate_out,
    output logic            timer2_clock_gate_out,
    output logic            timer0_clock_gate_out,
    output logic            timer1_clock_gate_out,
    output logic            spi_clock_gate_out,
    output logic            usart_clock_gate_out,
    output logic            converter_shutdown_out,
    output logic            comparator_mux_grant_out,
    output logic            bandgap_enable_out
);
    import reset_power_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Parameter checks

    if (STRETCH_LONG < 1 || STRETCH_LONG >= (1 << STRETCH_W)) begin : g_chk_long
        $error("STRETCH_LONG out of range");
    end
    if (STRETCH_SHORT < 1 || STRETCH_SHORT >= (1 << STRETCH_W)) begin : g_chk_short
        $error("STRETCH_SHORT out of range");
    end
    if (PIN_MIN < 1 || PIN_MIN >= (1 << FILT_W)) begin : g_chk_pin
        $error("PIN_MIN out of range");
    end
    if (DROP_MIN < 1 || DROP_MIN >= (1 << FILT_W)) begin : g_chk_drop
        $error("DROP_MIN out of range");
    end

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    // Stretch length from start-up and clock fuses; at start-up fuse value 2 crystal choices
    // get the long setting so oscillators settle before code runs.
    function automatic logic [STRETCH_W-1:0] stretch_len(
        input logic [1:0] startup_time_fuses,
        input logic [3:0] clock_select_fuses
    );
        logic [STRETCH_W-1:0] len;
        len = STRETCH_W'(STRETCH_FAST_CYC);
        case (startup_time_fuses)
            2'h0:    len = STRETCH_W'(STRETCH_FAST_CYC);
            2'h1:    len = STRETCH_W'(STRETCH_SHORT);
            2'h2:    len = clock_select_fuses[3] ? STRETCH_W'(STRETCH_LONG)
                                    : STRETCH_W'(STRETCH_SHORT);
            default: len = STRETCH_W'(STRETCH_LONG);
        endcase
        return len;
    endfunction : stretch_len

    // Saturating low-time filter shared by the pin and drop inputs
    function automatic logic [FILT_W-1:0] filt_step(
        input logic              active,
        input logic [FILT_W-1:0] cnt
    );
        logic [FILT_W-1:0] n;
        n = '0;
        if (active) begin
            n = (cnt == '1) ? cnt : cnt + FILT_W'(1);
        end
        return n;
    endfunction : filt_step

    //////////////////////////////////////////////////////////////////////////
    // State

    localparam state_t ST_RESET = '{
        pin_s:          2'h3,
        por_s:          2'h0,
        drop_s:         2'h0,
        pin_cnt:        '0,
        drop_cnt:       '0,
        pin_act:        1'b0,
        drop_act:       1'b0,
        wdt_pulse:      1'b0,
        phase:          PH_HOLD,
        stretch_cnt:    '0,
        int_rst:        1'b1,
        io_rst:         1'b1,
        fetch_start:    1'b0,
        gates:          GATES_RESET,
        win_cnt:        3'h0,
        sleep_off:      1'b0,
        sleep_off_age:  2'h0,
        sleep_off_pipe: 3'h0,
        det_off:        1'b0,
        rdata:          8'h00,
        gate_out:       7'h00,
        mux_grant:      1'b1,
        bandgap_en:     1'b0
    };

    state_t r;
    state_t s;

    logic   drop_fused;
    logic   por_act;
    logic   any_src;

    //////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s = r;
        s.fetch_start = 1'b0;

        // Pin-side levels pass two flops before use
        s.pin_s  = {r.pin_s[0], reset_pin_n_in};
        s.por_s  = {r.por_s[0], supply_up_ok_in};
        s.drop_s = {r.drop_s[0], supply_drop_in};

        drop_fused = (drop_level_fuses_in != DROP_FUSES_OFF);
        // Supply below level resets at once, no filter
        por_act = ~r.por_s[1];

        // Pin low must outlast the minimum width; fuse removes it
        s.pin_cnt = filt_step(~r.pin_s[1] & ~pin_reset_disable_fuse_in,
                              r.pin_cnt);
        s.pin_act = (s.pin_cnt >= FILT_W'(PIN_MIN));

        // Drop must outlast the detection time; detector off in a sleep entered in the window
        s.drop_cnt = filt_step(r.drop_s[1] & drop_fused & ~r.det_off,
                               r.drop_cnt);
        s.drop_act = (s.drop_cnt >= FILT_W'(DROP_MIN));

        // One-cycle watchdog reset pulse
        s.wdt_pulse = wdt_timeout_in & wdt_reset_mode_in;

        any_src = por_act | r.pin_act | r.wdt_pulse | r.drop_act;
        s.io_rst = any_src;

        // Sequencer: any source holds, release starts the stretch
        case (r.phase)
            PH_HOLD: begin
                s.int_rst     = 1'b1;
                s.stretch_cnt = '0;
                if (!any_src) begin
                    s.phase = PH_STRETCH;
                end
            end
            PH_STRETCH: begin
                s.int_rst = 1'b1;
                if (any_src) begin
                    s.phase = PH_HOLD;
                end else if (r.stretch_cnt >= stretch_len(startup_time_fuses_in,
                                                          clock_select_fuses_in)
                                              - STRETCH_W'(1)) begin
                    s.phase       = PH_RUN;
                    s.int_rst     = 1'b0;
                    s.fetch_start = 1'b1;
                end else begin
                    s.stretch_cnt = r.stretch_cnt + STRETCH_W'(1);
                end
            end
            PH_RUN: begin
                if (any_src) begin
                    s.phase   = PH_HOLD;
                    s.int_rst = 1'b1;
                end
            end
            default: begin
                s.phase   = PH_HOLD;
                s.int_rst = 1'b1;
            end
        endcase

        // Sleep-off timed sequence
        if (r.win_cnt != 3'h0) begin
            s.win_cnt = r.win_cnt - 3'h1;
        end
        if (r.sleep_off) begin
            if (r.sleep_off_age == SLEEP_OFF_CYC - 2'h1) begin
                s.sleep_off     = 1'b0;
                s.sleep_off_age = 2'h0;
            end else begin
                s.sleep_off_age = r.sleep_off_age + 2'h1;
            end
        end
        // Effective window lags the bit by three cycles
        s.sleep_off_pipe = {r.sleep_off_pipe[1:0], r.sleep_off};

        // Detector stays off only for the sleep entered in the window
        if (sleep_wake_in) begin
            s.det_off = 1'b0;
        end
        if (sleep_enter_in && r.sleep_off_pipe[2] && drop_fused) begin
            s.det_off = 1'b1;
        end

        // Register writes
        s.rdata = 8'h00;
        if (wr_in && !r.int_rst) begin
            case (addr_in)
                ADDR_CLOCK_GATES: begin
                    s.gates = wdata_in & GATES_WMASK;
                end
                ADDR_CORE_CTRL: begin
                    if (wdata_in[BIT_SLEEP_OFF] && wdata_in[BIT_SLEEP_WE]) begin
                        s.win_cnt = SEQ_WINDOW_CYC;
                    end else if (wdata_in[BIT_SLEEP_OFF] && r.win_cnt != 3'h0) begin
                        s.sleep_off     = 1'b1;
                        s.sleep_off_age = 2'h0;
                        s.win_cnt       = 3'h0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads, data in the following cycle
        if (rd_in) begin
            case (addr_in)
                ADDR_CLOCK_GATES: s.rdata = r.gates & GATES_WMASK;
                ADDR_CORE_CTRL: begin
                    s.rdata[BIT_SLEEP_OFF] = r.sleep_off;
                    s.rdata[BIT_SLEEP_WE]  = (r.win_cnt != 3'h0);
                end
                ADDR_STATUS: begin
                    s.rdata = {1'b0, r.bandgap_en, r.det_off, r.sleep_off_pipe[2],
                               r.drop_act, r.wdt_pulse, r.pin_act, por_act};
                end
                default: s.rdata = 8'h00;
            endcase
        end

        // Internal reset restores register contents
        if (r.int_rst) begin
            s.gates          = GATES_RESET;
            s.win_cnt        = 3'h0;
            s.sleep_off      = 1'b0;
            s.sleep_off_age  = 2'h0;
            s.sleep_off_pipe = 3'h0;
            s.det_off        = 1'b0;
        end

        // Gate outputs register together with the stored bits, in the same cycle
        s.gate_out[6] = s.gates[BIT_TWO_WIRE];
        // Asynchronous timer 2 keeps its own clock
        s.gate_out[5] = s.gates[BIT_TIMER2] & ~timer2_async_select_in;
        s.gate_out[4] = s.gates[BIT_TIMER0];
        s.gate_out[3] = s.gates[BIT_TIMER1];
        s.gate_out[2] = s.gates[BIT_SPI];
        s.gate_out[1] = s.gates[BIT_USART];
        s.gate_out[0] = s.gates[BIT_CONVERTER];
        s.mux_grant   = ~s.gates[BIT_CONVERTER];

        // Reference start-up is the user's wait, not gated here
        s.bandgap_en = drop_fused | comparator_bandgap_select_in
                     | converter_enable_in;
    end

    //////////////////////////////////////////////////////////////////////////
    // Register stage

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            r <= ST_RESET;
        end else begin
            r <= s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs

    // Port reset is one flop after the sources, not truly clockless
    assign rdata_out                    = r.rdata;
    assign internal_reset_out           = r.int_rst;
    assign io_port_reset_out            = r.io_rst;
    assign fetch_start_out              = r.fetch_start;
    assign supply_drop_detector_off_out = r.det_off;
    assign two_wire_clock_gate_out      = r.gate_out[6];
    assign timer2_clock_gate_out        = r.gate_out[5];
    assign timer0_clock_gate_out        = r.gate_out[4];
    assign timer1_clock_gate_out        = r.gate_out[3];
    assign spi_clock_gate_out           = r.gate_out[2];
    assign usart_clock_gate_out         = r.gate_out[1];
    assign converter_shutdown_out       = r.gate_out[0];
    assign comparator_mux_grant_out     = r.mux_grant;
    assign bandgap_enable_out           = r.bandgap_en;

endmodule : reset_and_power_reduction_ctrl

/* File: reset_power_pkg.sv */
/*
 * Constants and state types for the reset combiner, start-up stretch,
 * supply-drop sleep control and peripheral clock gates.
 * Assumes a single 200 MHz system clock and an 8-bit register port.
 */
package reset_power_pkg;

    // Clock and time base
    localparam int CLK_MHZ            = 200;
    localparam int PIN_MIN_NS         = 2500;
    localparam int DROP_MIN_NS        = 2000;
    localparam int STRETCH_LONG_US    = 65000;
    localparam int STRETCH_SHORT_US   = 4100;
    localparam int STRETCH_FAST_NS    = 70;
    // Least times round up to whole cycles
    localparam int PIN_MIN_CYC        = (PIN_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DROP_MIN_CYC       = (DROP_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int STRETCH_LONG_CYC   = STRETCH_LONG_US * CLK_MHZ;
    localparam int STRETCH_SHORT_CYC  = STRETCH_SHORT_US * CLK_MHZ;
    localparam int STRETCH_FAST_CYC   = (STRETCH_FAST_NS * CLK_MHZ + 999) / 1000;
    localparam int FILT_W             = 10;
    localparam int STRETCH_W          = 24;

    // Register map
    localparam logic [7:0] ADDR_CLOCK_GATES = 8'h64;
    localparam logic [7:0] ADDR_CORE_CTRL   = 8'h70;
    localparam logic [7:0] ADDR_STATUS      = 8'h71;
    localparam logic [7:0] GATES_RESET      = 8'h00;
    localparam logic [7:0] GATES_WMASK      = 8'hef;

    // Clock gate bit positions
    localparam int BIT_TWO_WIRE  = 7;
    localparam int BIT_TIMER2    = 6;
    localparam int BIT_TIMER0    = 5;
    localparam int BIT_TIMER1    = 3;
    localparam int BIT_SPI       = 2;
    localparam int BIT_USART     = 1;
    localparam int BIT_CONVERTER = 0;

    // Core control bit positions
    localparam int BIT_SLEEP_OFF = 6;
    localparam int BIT_SLEEP_WE  = 5;

    // Timed sequence figures
    localparam logic [2:0] SEQ_WINDOW_CYC = 3'h4;
    localparam logic [1:0] SLEEP_OFF_CYC  = 2'h3;

    // All level fuses high means the detector is off
    localparam logic [2:0] DROP_FUSES_OFF = 3'h7;

    typedef enum logic [1:0] {
        PH_HOLD,
        PH_STRETCH,
        PH_RUN
    } phase_t;

    typedef struct packed {
        logic [1:0]           pin_s;
        logic [1:0]           por_s;
        logic [1:0]           drop_s;
        logic [FILT_W-1:0]    pin_cnt;
        logic [FILT_W-1:0]    drop_cnt;
        logic                 pin_act;
        logic                 drop_act;
        logic                 wdt_pulse;
        phase_t               phase;
        logic [STRETCH_W-1:0] stretch_cnt;
        logic                 int_rst;
        logic                 io_rst;
        logic                 fetch_start;
        logic [7:0]           gates;
        logic [2:0]           win_cnt;
        logic                 sleep_off;
        logic [1:0]           sleep_off_age;
        logic [2:0]           sleep_off_pipe;
        logic                 det_off;
        logic [7:0]           rdata;
        logic [6:0]           gate_out;
        logic                 mux_grant;
        logic                 bandgap_en;
    } state_t;

endpackage : reset_power_pkg

/* File: reset_power_ctrl_props.sv */
/*
 * Concurrent checks on the reset and power reduction block ports.
 * Assumes one clock, synchronous active-high reset, bound by name.
 */
`timescale 1ns/1ps
module reset_power_ctrl_props import reset_power_pkg::*; (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic       supply_up_ok_in,
    input wire logic       wdt_timeout_in,
    input wire logic       wdt_reset_mode_in,
    input wire logic [2:0] drop_level_fuses_in,
    input wire logic       sleep_enter_in,
    input wire logic       sleep_wake_in,
    input wire logic       timer2_async_select_in,
    input wire logic       comparator_bandgap_select_in,
    input wire logic       converter_enable_in,
    input wire logic       internal_reset_out,
    input wire logic       io_port_reset_out,
    input wire logic       fetch_start_out,
    input wire logic       supply_drop_detector_off_out,
    input wire logic       two_wire_clock_gate_out,
    input wire logic       timer2_clock_gate_out,
    input wire logic       timer0_clock_gate_out,
    input wire logic       timer1_clock_gate_out,
    input wire logic       spi_clock_gate_out,
    input wire logic       usart_clock_gate_out,
    input wire logic       converter_shutdown_out,
    input wire logic       comparator_mux_grant_out,
    input wire logic       bandgap_enable_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////////
    // Writes only count once the core is out of reset
    logic gate_wr;
    assign gate_wr = wr_in && addr_in == ADDR_CLOCK_GATES && !internal_reset_out
                     && !io_port_reset_out;
    AST_GATES: assert property (gate_wr |=> {two_wire_clock_gate_out, timer0_clock_gate_out,
        timer1_clock_gate_out, spi_clock_gate_out, usart_clock_gate_out, converter_shutdown_out}
        == {$past(wdata_in[7]), $past(wdata_in[5]), $past(wdata_in[3]), $past(wdata_in[2]),
        $past(wdata_in[1]), $past(wdata_in[0])}) else $error("gate bits differ from write");
    AST_TIMER2: assert property (gate_wr |=> timer2_clock_gate_out ==
        ($past(wdata_in[6]) && !$past(timer2_async_select_in))) else $error("timer2 gate wrong");
    AST_MUX: assert property (comparator_mux_grant_out == !converter_shutdown_out)
        else $error("mux grant while converter shut");
    AST_RSVD: assert property (rd_in && addr_in == ADDR_CLOCK_GATES |=> !rdata_out[4])
        else $error("reserved gate bit read one");
    AST_BANDGAP: assert property (!$past(rst_in) && !$past(rst_in, 2) |->
        bandgap_enable_out == ($past(drop_level_fuses_in) != DROP_FUSES_OFF
        || $past(comparator_bandgap_select_in) || $past(converter_enable_in)))
        else $error("bandgap enable wrong");
    AST_FETCH: assert property (fetch_start_out |-> !internal_reset_out ##1 !fetch_start_out)
        else $error("fetch start pulse malformed");
    AST_STRETCH: assert property ($fell(io_port_reset_out) |-> internal_reset_out [*8])
        else $error("internal reset not stretched");
    AST_WDT: assert property (wdt_timeout_in && wdt_reset_mode_in |-> ##[1:3] io_port_reset_out)
        else $error("watchdog timeout gave no reset");
    AST_CORE: assert property (io_port_reset_out |-> ##[0:1] internal_reset_out)
        else $error("port reset without core reset");
    AST_SUPPLY_UP: assert property (!supply_up_ok_in ##1 !supply_up_ok_in |->
        ##[1:2] io_port_reset_out) else $error("supply low gave no reset");
    AST_DET_OFF: assert property ($rose(supply_drop_detector_off_out) |-> $past(sleep_enter_in))
        else $error("detector off without sleep");
    AST_WAKE: assert property (sleep_wake_in |=> !supply_drop_detector_off_out)
        else $error("detector still off after wake");
    cover property (fetch_start_out);
    cover property ($rose(supply_drop_detector_off_out));
    cover property (wdt_timeout_in && wdt_reset_mode_in);
endmodule : reset_power_ctrl_props

bind reset_and_power_reduction_ctrl reset_power_ctrl_props u_props (.*);

/* File: reset_and_power_reduction_ctrl_tb.sv */
/*
 * Self-checking bench: gate table, bandgap, timed sleep-off, reset sources.
 * Assumes small stretch and filter parameters; start-up fuses pick short.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if (!((a) === (b))) begin errors++; \
    $display("ERROR t=%0t got %h want %h", $time, (a), (b)); end end
module reset_and_power_reduction_ctrl_tb;
    import reset_power_pkg::*;
    logic sys_clk_in, rst_in, wr_in, rd_in, supply_up_ok_in, reset_pin_n_in, supply_drop_in;
    logic wdt_timeout_in, wdt_reset_mode_in, pin_reset_disable_fuse_in, sleep_enter_in;
    logic sleep_wake_in, timer2_async_select_in, comparator_bandgap_select_in;
    logic converter_enable_in, internal_reset_out, io_port_reset_out, fetch_start_out;
    logic supply_drop_detector_off_out, two_wire_clock_gate_out, timer2_clock_gate_out;
    logic timer0_clock_gate_out, timer1_clock_gate_out, spi_clock_gate_out;
    logic usart_clock_gate_out, converter_shutdown_out, comparator_mux_grant_out;
    logic bandgap_enable_out;
    logic [7:0] addr_in, wdata_in, rdata_out;
    logic [2:0] drop_level_fuses_in;
    logic [1:0] startup_time_fuses_in;
    logic [3:0] clock_select_fuses_in;
    int errors, n_tests;
    // Rows: write data, async select, read back, {gates, mux grant}
    logic [31:0] rows [6] = '{32'hff00_effe, 32'hff01_efbe, 32'h1000_0001,
                              32'ha500_a5aa, 32'h5a00_4a55, 32'h0000_0001};
    reset_and_power_reduction_ctrl #(.STRETCH_LONG(20), .STRETCH_SHORT(10), .PIN_MIN(3),
        .DROP_MIN(3)) u_dut (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        wr_in <= w; rd_in <= r; addr_in <= a; wdata_in <= d;
    endtask : bus
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask : idle
    task automatic rd(input logic [7:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        idle(1);
        #1;
    endtask : rd
    task automatic wait_rel;
        for (int k = 0; k < 100 && internal_reset_out !== 1'b0; k++) idle(1);
        #1;
        `CHK(internal_reset_out, 1'b0)
    endtask : wait_rel
    // Opener, gap, setter, read, then sleep in the effective window
    task automatic timed(input int gap, input logic exp);
        bus(1'b1, 1'b0, ADDR_CORE_CTRL, 8'h60);
        idle(gap);
        bus(1'b1, 1'b0, ADDR_CORE_CTRL, 8'h40);
        rd(ADDR_CORE_CTRL);
        `CHK(rdata_out[6], exp)
        idle(1);
        @(posedge sys_clk_in) sleep_enter_in <= 1'b1;
        @(posedge sys_clk_in) sleep_enter_in <= 1'b0;
        idle(2); #1;
        `CHK(supply_drop_detector_off_out, exp)
        rd(ADDR_CORE_CTRL);
        `CHK(rdata_out[6], 1'b0)
        @(posedge sys_clk_in) sleep_wake_in <= 1'b1;
        @(posedge sys_clk_in) sleep_wake_in <= 1'b0;
        idle(2); #1;
        `CHK(supply_drop_detector_off_out, 1'b0)
    endtask : timed
    // Source codes: 0 supply, 1 pin, 2 pin fused off, 3 drop, 4 drop fused off, 5/6 watchdog
    task automatic src(input int s, input logic exp);
        bus(1'b1, 1'b0, ADDR_CLOCK_GATES, 8'hff);
        @(posedge sys_clk_in) begin
            wr_in <= 1'b0;
            pin_reset_disable_fuse_in <= (s == 2);
            drop_level_fuses_in <= (s == 4) ? DROP_FUSES_OFF : 3'h4;
            wdt_reset_mode_in <= (s != 6);
        end
        @(posedge sys_clk_in) case (s)
            0: supply_up_ok_in <= 1'b0;
            1, 2: reset_pin_n_in <= 1'b0;
            3, 4: supply_drop_in <= 1'b1;
            default: wdt_timeout_in <= 1'b1;
        endcase
        @(posedge sys_clk_in) wdt_timeout_in <= 1'b0;
        repeat (9) @(posedge sys_clk_in);
        #1;
        `CHK(internal_reset_out, exp)
        // Landing only when no reset holds the core
        bus(1'b1, 1'b0, ADDR_CLOCK_GATES, 8'hff);
        idle(1);
        @(posedge sys_clk_in) begin
            supply_up_ok_in <= 1'b1; reset_pin_n_in <= 1'b1; supply_drop_in <= 1'b0;
        end
        wait_rel();
        rd(ADDR_CLOCK_GATES);
        `CHK(rdata_out, exp ? 8'h00 : 8'hef)
        bus(1'b1, 1'b0, ADDR_CLOCK_GATES, 8'h00);
    endtask : src
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #100000;
        errors++;
        complete_run();
    end
    initial begin
        {wr_in, rd_in, supply_drop_in, wdt_timeout_in, pin_reset_disable_fuse_in} = '0;
        {sleep_enter_in, sleep_wake_in, timer2_async_select_in} = '0;
        {comparator_bandgap_select_in, converter_enable_in, addr_in, wdata_in} = '0;
        {rst_in, supply_up_ok_in, reset_pin_n_in, wdt_reset_mode_in} = 4'hf;
        drop_level_fuses_in = 3'h4;
        startup_time_fuses_in = 2'h1;
        clock_select_fuses_in = 4'h0;
        errors = 0;
        n_tests = 0;
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        wait_rel();
        rd(ADDR_CLOCK_GATES);
        `CHK(rdata_out, GATES_RESET)
        foreach (rows[i]) begin
            @(posedge sys_clk_in) timer2_async_select_in <= rows[i][16];
            bus(1'b1, 1'b0, ADDR_CLOCK_GATES, rows[i][31:24]);
            idle(2); #1;
            `CHK({two_wire_clock_gate_out, timer2_clock_gate_out, timer0_clock_gate_out, timer1_clock_gate_out, spi_clock_gate_out, usart_clock_gate_out, converter_shutdown_out, comparator_mux_grant_out}, rows[i][7:0])
            rd(ADDR_CLOCK_GATES);
            `CHK(rdata_out, rows[i][15:8])
        end
        rd(8'h33);
        `CHK(rdata_out, 8'h00)
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_in) begin
                drop_level_fuses_in <= i[2] ? DROP_FUSES_OFF : 3'h4;
                comparator_bandgap_select_in <= i[1];
                converter_enable_in <= i[0];
            end
            idle(2); #1;
            `CHK(bandgap_enable_out, logic'(!i[2] || i[1] || i[0]))
        end
        @(posedge sys_clk_in) drop_level_fuses_in <= 3'h4;
        timed(0, 1'b1);
        timed(3, 1'b1);
        timed(4, 1'b0);
        for (int s = 0; s < 7; s++) src(s, logic'(s != 2 && s != 4 && s != 6));
        complete_run();
    end
endmodule : reset_and_power_reduction_ctrl_tb
